// ### hw/microcoded_cpu_sequencer.v
`timescale 1ns/1ns
`include "cpu_seq_regs.vh"

module microcoded_cpu_sequencer (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Shared 8-bit bus, three-signal form
    input wire [7:0] bus_in,
    output reg [7:0] bus_out,
    output reg [7:0] bus_oe,
    // Programmer pins
    input wire [7:0] user_input_pins,
    output reg prog_request,
    output reg byte_stored,
    output reg pins_to_bus,
    // Datapath controls
    output reg [14:0] ctrl_word,
    output reg halt_flag
);

    // ==========================================
    // Stage codes, one-hot
    localparam [5:0] ST_T0 = 6'h01;
    localparam [5:0] ST_T1 = 6'h02;
    localparam [5:0] ST_T2 = 6'h04;
    localparam [5:0] ST_T3 = 6'h08;
    localparam [5:0] ST_T4 = 6'h10;
    localparam [5:0] ST_T5 = 6'h20;

    // ==========================================
    // State
    reg [5:0] stage_q; // Current microstep
    reg [5:0] stage_d;
    reg [14:0] ctrl_d; // Control word for next stage
    reg halt_d;
    reg [3:0] pc_q; // Program counter
    reg [3:0] pc_d;
    reg [7:0] ir_q; // Instruction holder
    reg [7:0] bus_out_d;
    reg [7:0] bus_oe_d;
    reg [7:0] pins_s1_q; // Pin synchroniser, first stage
    reg [7:0] pins_s2_q; // Pin synchroniser, second stage
    reg prog_mode_q; // Programming mode from software
    reg clear_q; // One-cycle clear pulse from software
    reg wr_pend_q; // Write data phase pending
    reg [7:0] wr_addr_q; // Address of pending write
    wire [3:0] opcode;
    wire [3:0] operand;
    wire bus_take;

    // Opcode and operand split of the held byte
    assign opcode = ir_q[7:4];
    assign operand = ir_q[3:0];

    // ==========================================
    // Microcode lookup: stage plus opcode to control word
    function [14:0] lookup;
        input [5:0] st;
        input [3:0] op;
        input prog;
        reg [14:0] w;
        begin
            w = `CTRL_IDLE;
            // Common fetch
            case (st)
                ST_T0: begin
                    w[`B_PC_DRIVE] = 1'b1;
                    w[`B_ADDR_LATCH_N] = 1'b0;
                end
                ST_T1: begin
                    w[`B_PC_COUNT] = 1'b1;
                end
                ST_T2: begin
                    // Programmer gets a quiet cycle
                    if (!prog) begin
                        w[`B_MEM_DRIVE_N] = 1'b0;
                        w[`B_INSTR_LOAD_N] = 1'b0;
                    end
                end
                default: begin
                    w = `CTRL_IDLE;
                end
            endcase
            // Programming execute stages
            if (prog) begin
                if (st == ST_T3) begin
                    w[`B_WDATA_LATCH_N] = 1'b0;
                end
                if (st == ST_T4) begin
                    w[`B_MEM_WRITE_N] = 1'b0;
                end
            end else begin
                // Execute stages per opcode
                case (op)
                    `OP_ADD, `OP_SUB, `OP_LOAD_ACC, `OP_STORE_ACC: begin
                        if (st == ST_T3) begin
                            w[`B_INSTR_DRIVE_N] = 1'b0;
                            w[`B_ADDR_LATCH_N] = 1'b0;
                        end
                        if (st == ST_T4) begin
                            if (op == `OP_STORE_ACC) begin
                                w[`B_ACC_DRIVE] = 1'b1;
                                w[`B_WDATA_LATCH_N] = 1'b0;
                            end else begin
                                w[`B_MEM_DRIVE_N] = 1'b0;
                            end
                            if (op == `OP_LOAD_ACC) begin
                                w[`B_ACC_LOAD_N] = 1'b0;
                            end
                            if (op == `OP_ADD || op == `OP_SUB) begin
                                w[`B_OPB_LOAD_N] = 1'b0;
                            end
                        end
                        if (st == ST_T5) begin
                            if (op == `OP_STORE_ACC) begin
                                w[`B_MEM_WRITE_N] = 1'b0;
                            end
                            if (op == `OP_ADD || op == `OP_SUB) begin
                                w[`B_ALU_DRIVE] = 1'b1;
                                w[`B_ACC_LOAD_N] = 1'b0;
                                w[`B_SUB_SEL] = (op == `OP_SUB);
                            end
                        end
                    end
                    `OP_OUTPUT: begin
                        if (st == ST_T3) begin
                            w[`B_ACC_DRIVE] = 1'b1;
                            w[`B_OUTREG_LOAD_N] = 1'b0;
                        end
                    end
                    `OP_JUMP: begin
                        if (st == ST_T3) begin
                            w[`B_INSTR_DRIVE_N] = 1'b0;
                            w[`B_PC_LOAD] = 1'b1;
                        end
                    end
                    // Halt and idle: fetch only, halt handled apart
                    default: begin
                        w = w;
                    end
                endcase
            end
            lookup = w;
        end
    endfunction

    // ==========================================
    // Next stage, control word and halt
    always @* begin
        if (halt_flag) begin
            // Frozen, nothing active
            stage_d = stage_q;
            ctrl_d = `CTRL_IDLE;
            halt_d = 1'b1;
        end else begin
            // Six-stage ring
            stage_d = {stage_q[4:0], stage_q[5]};
            ctrl_d = lookup(stage_d, opcode, prog_mode_q);
            // Halt opcode reaching T3
            halt_d = (stage_d == ST_T3) && (opcode == `OP_HALT)
                && !prog_mode_q;
            if (halt_d) begin
                ctrl_d = `CTRL_IDLE;
            end
        end
    end

    // ==========================================
    // Program counter next value, load before count
    // Clear sits in the falling-edge process and beats both
    always @* begin
        if (ctrl_word[`B_PC_LOAD]) begin
            pc_d = bus_in[3:0];
        end else if (ctrl_word[`B_PC_COUNT]) begin
            pc_d = pc_q + 4'h1;
        end else begin
            pc_d = pc_q;
        end
    end

    // ==========================================
    // Bus drive for the next stage, single source
    // Chosen one stage ahead and registered, so two sources never overlap
    always @* begin
        bus_out_d = 8'h00;
        bus_oe_d = 8'h00;
        if (prog_mode_q && stage_d == ST_T3 && !halt_flag) begin
            // Pins onto bus while write data latches
            bus_out_d = pins_s2_q;
            bus_oe_d = 8'hff;
        end else if (ctrl_d[`B_PC_DRIVE]) begin
            // Counter on low nibble only
            bus_out_d = {4'h0, pc_d};
            bus_oe_d = 8'h0f;
        end else if (!ctrl_d[`B_INSTR_DRIVE_N]) begin
            // Address field on low nibble
            bus_out_d = {4'h0, operand};
            bus_oe_d = 8'h0f;
        end else begin
            // Released, high impedance
            bus_out_d = 8'h00;
            bus_oe_d = 8'h00;
        end
    end

    // ==========================================
    // Falling-edge sequencer and counter
    // Outputs settle half a cycle before the datapath's rising edge
    // Clear pulse lasts one rising-edge cycle, so one falling edge sees it
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_q <= ST_T5;
            ctrl_word <= `CTRL_IDLE;
            halt_flag <= 1'b0;
            pc_q <= 4'h0;
            bus_out <= 8'h00;
            bus_oe <= 8'h00;
            prog_request <= 1'b0;
            byte_stored <= 1'b0;
            pins_to_bus <= 1'b0;
        end else if (clear_q) begin
            // Clear wins over load and count
            stage_q <= ST_T5;
            ctrl_word <= `CTRL_IDLE;
            halt_flag <= 1'b0;
            pc_q <= 4'h0;
            bus_out <= 8'h00;
            bus_oe <= 8'h00;
            prog_request <= 1'b0;
            byte_stored <= 1'b0;
            pins_to_bus <= 1'b0;
        end else begin
            // Update on falling edge for rising-edge datapath
            stage_q <= stage_d;
            ctrl_word <= ctrl_d;
            halt_flag <= halt_d;
            pc_q <= pc_d;
            bus_out <= bus_out_d;
            bus_oe <= bus_oe_d;
            // Programmer handshake flags
            prog_request <= prog_mode_q && !halt_flag
                && stage_d == ST_T0;
            pins_to_bus <= prog_mode_q && !halt_flag
                && stage_d == ST_T3;
            byte_stored <= prog_mode_q && !halt_flag
                && stage_d == ST_T4;
        end
    end

    // ==========================================
    // Instruction holder, rising edge
    // Loads mid-stage, once the falling edge has settled the controls
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_q <= 8'h00;
        end else if (clear_q) begin
            ir_q <= 8'h00;
        end else if (!ctrl_word[`B_INSTR_LOAD_N]) begin
            ir_q <= bus_in;
        end
    end

    // ==========================================
    // Input pin synchroniser
    // Pins are asynchronous; the programmer must hold them from T1 on
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_s1_q <= 8'h00;
            pins_s2_q <= 8'h00;
        end else begin
            pins_s1_q <= user_input_pins;
            pins_s2_q <= pins_s1_q;
        end
    end

    // ==========================================
    // AHB-Lite slave, zero wait states
    // No wait states and OKAY only: ready and response never move
    assign bus_take = hsel && htrans[1] && hready;

    // Address phase capture and read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= bus_take && hwrite;
            wr_addr_q <= haddr[7:0];
            hrdata <= 32'h0000_0000;
            // Reads answer in the next cycle
            if (bus_take && !hwrite) begin
                case (haddr[7:0])
                    `OFS_CTRL: begin
                        hrdata <= {31'h0, prog_mode_q};
                    end
                    `OFS_STATUS: begin
                        // Bit 11 is spare and reads zero
                        hrdata <= {12'h000, ir_q, 1'b0, stage_q,
                            pc_q, halt_flag};
                    end
                    `OFS_CWORD: begin
                        hrdata <= {17'h00000, ctrl_word};
                    end
                    default: begin
                        hrdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Write data phase: mode bit and clear pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Leaves reset in run mode
            prog_mode_q <= `PROG_MODE_RESET;
            clear_q <= 1'b0;
        end else begin
            clear_q <= 1'b0;
            if (wr_pend_q && wr_addr_q == `OFS_CTRL) begin
                prog_mode_q <= hwdata[`F_PROG_MODE];
                clear_q <= hwdata[`F_CLEAR];
            end
        end
    end

endmodule

// ### common/cpu_seq_regs.vh
// Function
// - Opcodes zero to seven select eight instructions
// - Upper nibble opcode, lower nibble address operand
// - Fifteen-bit control word with fixed bit order
// - Six-stage microstep counter with opcode lookup
// - Stage and controls change on falling edge
// - Common fetch: T0 address, T1 count, T2 load
// - Idle opcode does fetch only
// - Halt opcode sets halt register at T3
// - One bus driver per cycle, many loaders
// - Program counter wraps from fifteen to zero
// - Counter increments only with count enable
// - Counter changes only on falling edge
// - Counter drives bus only with drive enable
// - Load enable loads bus; jump uses it
// - Counter uses low four bus bits only
// - Clear beats load, load beats count
// - Holder captures bus byte, presents opcode nibble
// - Holder drives address field only when enabled
// - Programming T0 fetches address, raises request
// - Programming T1 counts, drops request; T2 idle
// - Programming T3 loads write data, pins drive bus
// - Programming T4 writes, flags stored; T5 drops
`ifndef CPU_SEQ_REGS_VH
`define CPU_SEQ_REGS_VH

// ==========================================
// Opcodes
`define OP_HALT 4'h0
`define OP_IDLE 4'h1
`define OP_ADD 4'h2
`define OP_SUB 4'h3
`define OP_LOAD_ACC 4'h4
`define OP_OUTPUT 4'h5
`define OP_STORE_ACC 4'h6
`define OP_JUMP 4'h7

// ==========================================
// Control word bit positions
`define B_PC_COUNT 14
`define B_PC_DRIVE 13
`define B_PC_LOAD 12
`define B_ADDR_LATCH_N 11
`define B_WDATA_LATCH_N 10
`define B_MEM_DRIVE_N 9
`define B_MEM_WRITE_N 8
`define B_INSTR_LOAD_N 7
`define B_INSTR_DRIVE_N 6
`define B_ACC_LOAD_N 5
`define B_ACC_DRIVE 4
`define B_SUB_SEL 3
`define B_ALU_DRIVE 2
`define B_OPB_LOAD_N 1
`define B_OUTREG_LOAD_N 0
// All controls inactive: low-active bits high
`define CTRL_IDLE 15'h0fe3

// ==========================================
// Register map (byte addresses) and fields
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CWORD 8'h08
`define F_PROG_MODE 0
`define F_CLEAR 1
`define CTRL_RESET 32'h0000_0000
`define PROG_MODE_RESET 1'b0

`endif

// ### sim/cpu_seq_chk.sv
`timescale 1ns/1ns
module cpu_seq_chk (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Shared bus and pins
    input wire [7:0] bus_in,
    input wire [7:0] bus_out,
    input wire [7:0] bus_oe,
    input wire [7:0] user_input_pins,
    // Sequencer outputs
    input wire prog_request,
    input wire byte_stored,
    input wire pins_to_bus,
    input wire [14:0] ctrl_word,
    input wire halt_flag
);
    logic [3:0] op_q; // Opcode of last fetch
    logic [3:0] adr_q; // Operand of last fetch
    // ======
    // Expected words of stages T3 to T5
    function automatic logic [14:0] exp_w(input logic [3:0] op, input logic [3:0] s);
        case ({op, s})
            8'h23, 8'h33, 8'h43, 8'h63: return 15'h07a3;
            8'h24, 8'h34: return 15'h0de1;
            8'h25: return 15'h0fc7;
            8'h35: return 15'h0fcf;
            8'h44: return 15'h0dc3;
            8'h53: return 15'h0ff2;
            8'h64: return 15'h0bf3;
            8'h65: return 15'h0ee3;
            8'h73: return 15'h1fa3;
            default: return 15'h0fe3;
        endcase
    endfunction
    // Copy of the fetched byte
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q <= 4'h0;
            adr_q <= 4'h0;
        end else if (!ctrl_word[7]) begin
            op_q <= bus_in[7:4];
            adr_q <= bus_in[3:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ======
    // Step sequences
    sequence fetch_s;
        ctrl_word == 15'h4fe3 ##1 ctrl_word == 15'h0d63;
    endsequence
    sequence prog_head_s;
        (ctrl_word == 15'h4fe3 && !prog_request) ##1 (ctrl_word == 15'h0fe3 && !pins_to_bus);
    endsequence
    sequence prog_tail_s;
        (ctrl_word == 15'h0be3 && pins_to_bus)
        ##1 (ctrl_word == 15'h0ee3 && byte_stored && !pins_to_bus)
        ##1 (ctrl_word == 15'h0fe3 && !byte_stored);
    endsequence
    fetch_seq_a: assert property (
        ctrl_word == 15'h27e3 && !prog_request |=> fetch_s)
        else $error("fetch steps wrong");
    exec_words_a: assert property (
        ctrl_word == 15'h0d63 |=> ctrl_word == exp_w(op_q, 4'h3)
        ##1 ctrl_word == exp_w(op_q, 4'h4) ##1 ctrl_word == exp_w(op_q, 4'h5))
        else $error("stage word wrong for opcode");
    instr_drive_a: assert property (
        !ctrl_word[6] |-> bus_out[3:0] == adr_q && bus_oe == 8'h0f)
        else $error("operand drive wrong");
    bus_owner_a: assert property (
        !(ctrl_word[13] && !ctrl_word[6]) && bus_oe ==
        (pins_to_bus ? 8'hff : (ctrl_word[13] || !ctrl_word[6]) ? 8'h0f : 8'h00))
        else $error("bus enable wrong");
    pc_step_a: assert property (
        prog_request |-> ##6 prog_request
        && bus_out[3:0] - $past(bus_out[3:0], 6) == 4'h1)
        else $error("counter step wrong");
    prog_seq_a: assert property (
        prog_request && ctrl_word == 15'h27e3 |=> prog_head_s ##1 prog_tail_s)
        else $error("programming steps wrong");
    pins_data_a: assert property (
        pins_to_bus |-> bus_out == user_input_pins && bus_oe == 8'hff)
        else $error("pin data not on bus");
    halt_hold_a: assert property (
        halt_flag && $past(halt_flag) |-> ctrl_word == 15'h0fe3
        && bus_oe == 8'h00 && !prog_request)
        else $error("halted sequencer moved");
    halt_entry_a: assert property (
        $rose(halt_flag) |-> $past(ctrl_word) == 15'h0d63 && op_q == 4'h0)
        else $error("halt set at wrong step");
endmodule

// ### sim/prog_mcu_model.sv
`timescale 1ns/1ns
module prog_mcu_model (
    // Clock and handshake
    input wire hclk,
    input wire prog_request,
    input wire byte_stored,
    // Byte and answer speed
    input wire [7:0] byte_in,
    input wire slow,
    // Pins and progress
    output logic [7:0] pins,
    output int n_sent
);
    logic hold_q = 1'b0; // Byte held on pins
    initial pins = 8'ha5;
    initial n_sent = 0;
    // Answer each request; pins wander when not held
    always @(posedge hclk) begin
        if (prog_request) begin
            hold_q <= 1'b1;
            pins <= #(slow ? 60 : 1) byte_in;
        end else if (hold_q && byte_stored) begin
            hold_q <= 1'b0;
            n_sent <= n_sent + 1;
        end else if (!hold_q) begin
            pins <= ~pins;
        end
    end
endmodule

// ### sim/test_microcoded_cpu_sequencer.sv
`timescale 1ns/1ns
`include "cpu_seq_regs.vh"
module test_microcoded_cpu_sequencer;
    // Bus master and pins
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, prog_request, byte_stored, pins_to_bus, halt_flag;
    wire [7:0] bus_out, bus_oe, pins, ext, bus_in;
    wire [14:0] ctrl_word;
    // Memory model and program image
    logic [7:0] mem [16] = '{default: 8'h00};
    logic [7:0] img [16] = '{8'h10, 8'h4e, 8'h2e, 8'h3e, 8'h50, 8'h6d, 8'h79, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [3:0] mar_a = 4'h0;
    logic [7:0] mar_d = 8'h00, float_q = 8'h00;
    int n_sent, err_count = 0, n_compared = 0, i;
    wire slow = n_sent[0];
    wire [7:0] byte_nx = img[n_sent[3:0]];
    // Far side: memory, datapath constant or moving pattern
    assign ext = !ctrl_word[9] ? mem[mar_a] : (ctrl_word[4] || ctrl_word[2]) ? 8'h5a : float_q;
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & ext);
    // Clock
    initial forever #50 hclk = ~hclk;
    // Latch and memory actions
    always @(posedge hclk) begin
        float_q <= float_q + 8'h37;
        if (!ctrl_word[11]) mar_a <= bus_in[3:0];
        if (!ctrl_word[10]) mar_d <= bus_in;
        if (!ctrl_word[8]) mem[mar_a] <= mar_d;
    end
    microcoded_cpu_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_in(bus_in),
        .bus_out(bus_out),
        .bus_oe(bus_oe), .user_input_pins(pins), .prog_request(prog_request),
        .byte_stored(byte_stored), .pins_to_bus(pins_to_bus), .ctrl_word(ctrl_word),
        .halt_flag(halt_flag));
    prog_mcu_model mcu (.hclk(hclk), .prog_request(prog_request), .byte_stored(byte_stored),
        .byte_in(byte_nx), .slow(slow), .pins(pins), .n_sent(n_sent));
    // ======
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One single transfer; waits for ready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // ======
    // Scenarios
    task automatic t_reset_halt;
        ahb(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl reset", rd, `CTRL_RESET);
        check("ready and okay", {hreadyout, hresp}, 32'h2);
        ahb(1'b1, 32'h10, 32'hffff_ffff);
        ahb(1'b0, 32'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        for (i = 0; i < 50 && halt_flag !== 1'b1; i++) @(posedge hclk);
        ahb(1'b0, `OFS_STATUS, 32'h0);
        check("halt status", rd[4:0], 5'h03);
        ahb(1'b0, `OFS_CWORD, 32'h0);
        check("halted word", rd, `CTRL_IDLE);
    endtask
    task automatic t_program;
        ahb(1'b1, `OFS_CTRL, 32'h3);
        ahb(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl mode", rd, 32'h1);
        for (i = 0; i < 400 && n_sent < 16; i++) @(posedge hclk);
        for (i = 0; i < 16; i++) check("mem byte", mem[i], img[i]);
        for (i = 0; i < 8 && prog_request !== 1'b1; i++) @(posedge hclk);
        check("pc wrap", {bus_oe, bus_out[3:0]}, 12'h0f0);
    endtask
    task automatic t_run;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 200 && halt_flag !== 1'b1; i++) @(posedge hclk);
        check("stored acc", mem[13], 8'h5a);
        ahb(1'b0, `OFS_STATUS, 32'h0);
        check("jump pc", rd[4:0], 5'h15);
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_halt();
        t_program();
        t_run();
        report_and_stop();
    end
    // Watchdog
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end
endmodule
bind microcoded_cpu_sequencer cpu_seq_chk chk (.hclk(hclk), .hresetn(hresetn), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .user_input_pins(user_input_pins),
    .prog_request(prog_request), .byte_stored(byte_stored), .pins_to_bus(pins_to_bus),
    .ctrl_word(ctrl_word), .halt_flag(halt_flag));
